// ==== logic/timer16_pkg.sv ====
package timer16_pkg;
    // register offsets on the internal data bus
    localparam logic [7:0] FLAG_OFS       = 8'h36;
    localparam logic [7:0] CTRL_B_OFS     = 8'h81;
    localparam logic [7:0] FORCE_OFS      = 8'h82;
    localparam logic [7:0] CNT_LO_OFS     = 8'h84;
    localparam logic [7:0] CNT_HI_OFS     = 8'h85;
    localparam logic [7:0] CAP_LO_OFS     = 8'h86;
    localparam logic [7:0] CAP_HI_OFS     = 8'h87;
    // control b fields
    localparam int         FILTER_BIT     = 7;
    localparam int         EDGE_BIT       = 6;
    localparam int         WGM3_BIT       = 4;
    localparam int         WGM2_BIT       = 3;
    localparam int         CS_MSB         = 2;
    localparam logic [7:0] CTRL_B_MASK    = 8'hDF;
    localparam logic [7:0] CTRL_B_RESET   = 8'h00;
    // force compare and flag fields
    localparam int         FORCE_A_BIT    = 7;
    localparam int         FORCE_B_BIT    = 6;
    localparam int         CAP_FLAG_BIT   = 5;
    // clock select codes
    localparam logic [2:0] CS_STOP        = 3'h0;
    localparam logic [2:0] CS_DIV1        = 3'h1;
    localparam logic [2:0] CS_DIV8        = 3'h2;
    localparam logic [2:0] CS_DIV64       = 3'h3;
    localparam logic [2:0] CS_DIV256      = 3'h4;
    localparam logic [2:0] CS_DIV1024     = 3'h5;
    localparam logic [2:0] CS_EXT_FALL    = 3'h6;
    localparam logic [2:0] CS_EXT_RISE    = 3'h7;
    localparam int         PRESC_W        = 10;
    localparam logic [9:0] PRESC_MASK8    = 10'h007;
    localparam logic [9:0] PRESC_MASK64   = 10'h03F;
    localparam logic [9:0] PRESC_MASK256  = 10'h0FF;
    localparam logic [9:0] PRESC_MASK1024 = 10'h3FF;
    // noise filter length in samples
    localparam int         FILTER_LEN     = 4;
    // waveform modes used here
    localparam logic [3:0] WGM_NORMAL     = 4'h0;
    localparam logic [3:0] WGM_CTC_CMPA   = 4'h4;
    localparam logic [3:0] WGM_CTC_CAP    = 4'hC;
    localparam logic [15:0] TOP_MAX       = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT      = 16'h00FF;
    localparam logic [15:0] TOP_9BIT      = 16'h01FF;
    localparam logic [15:0] TOP_10BIT     = 16'h03FF;
    // compare output mode actions
    localparam logic [1:0] COM_OFF        = 2'h0;
    localparam logic [1:0] COM_TOGGLE     = 2'h1;
    localparam logic [1:0] COM_CLEAR      = 2'h2;
    localparam logic [1:0] COM_SET        = 2'h3;
endpackage : timer16_pkg

// ==== logic/timer16_capture_clock_control.sv ====
`timescale 1ns/10ps
// Summary of operation
// [R1] filter output changes after four equal samples
// [R2] filtered capture lags unfiltered by four cycles
// [R3] edge select: 0 falling, 1 rising
// [R4] capture copies counter and sets capture flag
// [R5] capture pin ignored when capture is top
// [R6] clock select: stop or prescaled io clock
// [R7] codes 110/111 count external pin edges
// [R8] force bits only act in non-pwm modes
// [R9] force applies compare action to waveform output
// [R10] force sets no flag, clears no counter
// [R11] force bits are strobes, read zero
// [R12] counter readable and writable as two bytes
// [R13] one shared high-byte latch for atomic access
// [R14] counter write blocks next compare match
// [R15] comparator output may serve as capture source
// [R16] software avoids writing running counter
// [R17] capture flag cleared by vector or write-one
// [R18] capture flag set at top when capture is top
// [R19] high byte first on write, low first read
// [R20] reset clears control, counter and capture
module timer16_capture_clock_control
    import timer16_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // internal data bus
    input  wire logic [7:0]  bus_addr,
    input  wire logic [7:0]  bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic      [7:0]  bus_rdata,
    // pins and comparator
    input  wire logic        capture_pin,
    input  wire logic        ext_count_pin,
    input  wire logic        comparator_out,
    input  wire logic        capture_src_comparator,
    // neighbouring timer settings
    input  wire logic [1:0]  waveform_mode_lo,
    input  wire logic [1:0]  compare_output_mode_a,
    input  wire logic [1:0]  compare_output_mode_b,
    input  wire logic [15:0] compare_a_value,
    input  wire logic [15:0] compare_b_value,
    input  wire logic        capture_vector_ack,
    // results
    output logic [15:0]      counter_value,
    output logic [15:0]      capture_value,
    output logic             capture_flag,
    output logic             compare_match_a,
    output logic             compare_match_b,
    output logic             waveform_out_a,
    output logic             waveform_out_b
);

    logic [7:0]         ctrl_b_r;
    logic [7:0]         temp_r;
    logic [PRESC_W-1:0] presc_r;
    logic [1:0]         cap_sync_r;
    logic [2:0]         ext_sync_r;
    logic [1:0]         cmp_sync_r;
    logic [FILTER_LEN-2:0] filt_hist_r;
    logic               filt_r;
    logic               edge_prev_r;
    logic               block_r;
    logic [3:0]         wgm;
    logic [2:0]         cs;
    logic               tick;
    logic               non_pwm;
    logic               cap_is_top;
    logic [15:0]        top_val;
    logic               edge_src;
    logic               cap_trig;
    logic               top_hit;
    logic               match_a;
    logic               match_b;
    logic               force_a;
    logic               force_b;
    logic               wr_cnt_lo;
    logic               wr_cap_lo;
    logic               rd_cnt_lo;
    logic               rd_cap_lo;

    assign wgm       = {ctrl_b_r[WGM3_BIT], ctrl_b_r[WGM2_BIT], waveform_mode_lo};
    assign cs        = ctrl_b_r[CS_MSB:0];
    assign wr_cnt_lo = bus_wr && (bus_addr == CNT_LO_OFS);
    assign wr_cap_lo = bus_wr && (bus_addr == CAP_LO_OFS);
    assign rd_cnt_lo = bus_rd && (bus_addr == CNT_LO_OFS);
    assign rd_cap_lo = bus_rd && (bus_addr == CAP_LO_OFS);

    always_comb begin
        non_pwm = (wgm == WGM_NORMAL) || (wgm == WGM_CTC_CMPA) ||
                  (wgm == WGM_CTC_CAP);
        cap_is_top = (wgm == 4'h8) || (wgm == 4'hA) || (wgm == WGM_CTC_CAP) ||
                     (wgm == 4'hE);
        case (wgm)
            4'h1, 4'h5: top_val = TOP_8BIT;
            4'h2, 4'h6: top_val = TOP_9BIT;
            4'h3, 4'h7: top_val = TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: top_val = compare_a_value;
            4'h8, 4'hA, 4'hC, 4'hE: top_val = capture_value;
            default: top_val = TOP_MAX;
        endcase
    end

    // clock source decode
    always_comb begin
        case (cs)
            CS_STOP:     tick = 1'b0; // [R6]
            CS_DIV1:     tick = 1'b1; // [R6]
            CS_DIV8:     tick = &(presc_r | ~PRESC_MASK8); // [R6]
            CS_DIV64:    tick = &(presc_r | ~PRESC_MASK64); // [R6]
            CS_DIV256:   tick = &(presc_r | ~PRESC_MASK256); // [R6]
            CS_DIV1024:  tick = &(presc_r | ~PRESC_MASK1024); // [R6]
            CS_EXT_FALL: tick = ext_sync_r[2] && !ext_sync_r[1]; // [R7]
            CS_EXT_RISE: tick = !ext_sync_r[2] && ext_sync_r[1]; // [R7]
            default:     tick = 1'b0;
        endcase
    end

    // free-running prescaler; shared taps keep divided ticks aligned
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            presc_r <= '0;
        end else begin
            presc_r <= presc_r + 1'b1;
        end
    end

    // pin synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cap_sync_r <= '0;
            ext_sync_r <= '0;
            cmp_sync_r <= '0;
        end else begin
            cap_sync_r <= {cap_sync_r[0], capture_pin};
            ext_sync_r <= {ext_sync_r[1:0], ext_count_pin};
            cmp_sync_r <= {cmp_sync_r[0], comparator_out};
        end
    end

    // noise filter on the synchronised capture pin
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            filt_hist_r <= '0;
            filt_r      <= 1'b0;
        end else begin
            filt_hist_r <= {filt_hist_r[FILTER_LEN-3:0], cap_sync_r[1]};
            // the live sample is the fourth, so no extra cycle of lag
            if (&{filt_hist_r, cap_sync_r[1]}) begin
                filt_r <= 1'b1; // [R1] [R2]
            end else if (~|{filt_hist_r, cap_sync_r[1]}) begin
                filt_r <= 1'b0; // [R1] [R2]
            end
        end
    end

    always_comb begin
        if (capture_src_comparator) begin
            edge_src = cmp_sync_r[1]; // [R15]
        end else if (ctrl_b_r[FILTER_BIT]) begin
            edge_src = filt_r; // [R1]
        end else begin
            edge_src = cap_sync_r[1];
        end
    end

    // edge detect; pin disconnected while capture value is top
    assign cap_trig = !cap_is_top && (ctrl_b_r[EDGE_BIT] ?
                      (edge_src && !edge_prev_r) :
                      (!edge_src && edge_prev_r)); // [R3] [R5]
    assign top_hit  = tick && (counter_value == top_val);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            edge_prev_r <= 1'b0;
        end else begin
            edge_prev_r <= edge_src;
        end
    end

    // control register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_b_r <= CTRL_B_RESET; // [R20]
        end else if (bus_wr && bus_addr == CTRL_B_OFS) begin
            ctrl_b_r <= bus_wdata & CTRL_B_MASK;
        end
    end

    // shared high-byte latch
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            temp_r <= '0;
        end else if (bus_wr && (bus_addr == CNT_HI_OFS ||
                                bus_addr == CAP_HI_OFS)) begin
            temp_r <= bus_wdata; // [R13] [R19]
        end else if (rd_cnt_lo) begin
            temp_r <= counter_value[15:8]; // [R13] [R19]
        end else if (rd_cap_lo) begin
            temp_r <= capture_value[15:8]; // [R13] [R19]
        end
    end

    // counter; a bus write wins over a tick in the same cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            counter_value <= '0; // [R20]
        end else if (wr_cnt_lo) begin
            counter_value <= {temp_r, bus_wdata}; // [R12] [R19]
        end else if (tick) begin
            // dual-slope counting is not modelled: all modes count up
            if (counter_value == top_val && !block_r) begin
                counter_value <= '0;
            end else begin
                counter_value <= counter_value + 1'b1;
            end
        end
    end

    // compare block after a counter write, released by the next tick
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            block_r <= 1'b0;
        end else if (wr_cnt_lo) begin
            block_r <= 1'b1; // [R14] [R16]
        end else if (tick) begin
            block_r <= 1'b0; // [R14]
        end
    end

    // capture register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            capture_value <= '0; // [R20]
        end else if (cap_trig) begin
            capture_value <= counter_value; // [R4]
        end else if (wr_cap_lo) begin
            capture_value <= {temp_r, bus_wdata}; // [R19]
        end
    end

    // capture flag; a set in the clearing cycle wins
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            capture_flag <= 1'b0;
        end else if (cap_trig || (cap_is_top && top_hit)) begin
            capture_flag <= 1'b1; // [R4] [R18]
        end else if (capture_vector_ack || (bus_wr && bus_addr == FLAG_OFS &&
                     bus_wdata[CAP_FLAG_BIT])) begin
            capture_flag <= 1'b0; // [R17]
        end
    end

    // compare matches and forced strobes
    assign match_a = tick && !block_r && (counter_value == compare_a_value);
    assign match_b = tick && !block_r && (counter_value == compare_b_value);
    assign force_a = non_pwm && bus_wr && (bus_addr == FORCE_OFS) &&
                     bus_wdata[FORCE_A_BIT]; // [R8] [R11]
    assign force_b = non_pwm && bus_wr && (bus_addr == FORCE_OFS) &&
                     bus_wdata[FORCE_B_BIT]; // [R8] [R11]

    // match pulses exclude forced compares
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            compare_match_a <= 1'b0;
            compare_match_b <= 1'b0;
        end else begin
            compare_match_a <= match_a; // [R10] [R14]
            compare_match_b <= match_b; // [R10] [R14]
        end
    end

    // waveform outputs driven in non-pwm modes only; pwm shaping lives
    // in the waveform generator outside this block
    function automatic logic com_apply(input logic [1:0] com,
                                       input logic cur);
        case (com)
            COM_TOGGLE: com_apply = !cur;
            COM_CLEAR:  com_apply = 1'b0;
            COM_SET:    com_apply = 1'b1;
            default:    com_apply = cur;
        endcase
    endfunction : com_apply

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            waveform_out_a <= 1'b0;
            waveform_out_b <= 1'b0;
        end else if (non_pwm) begin
            if (force_a || match_a) begin
                waveform_out_a <= com_apply(compare_output_mode_a,
                                            waveform_out_a); // [R9]
            end
            if (force_b || match_b) begin
                waveform_out_b <= com_apply(compare_output_mode_b,
                                            waveform_out_b); // [R9]
            end
        end
    end

    // read data, valid the cycle after the read strobe
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bus_rdata <= '0;
        end else if (bus_rd) begin
            case (bus_addr)
                FLAG_OFS:   bus_rdata <= {2'h0, capture_flag, 5'h00};
                CTRL_B_OFS: bus_rdata <= ctrl_b_r;
                FORCE_OFS:  bus_rdata <= 8'h00; // [R11]
                CNT_LO_OFS: bus_rdata <= counter_value[7:0]; // [R12]
                CNT_HI_OFS: bus_rdata <= temp_r; // [R12] [R13]
                CAP_LO_OFS: bus_rdata <= capture_value[7:0];
                CAP_HI_OFS: bus_rdata <= temp_r; // [R13]
                default:    bus_rdata <= 8'h00;
            endcase
        end
    end

endmodule : timer16_capture_clock_control

// ==== testbench/timer16_properties.sv ====
`timescale 1ns/10ps
module timer16_properties
    import timer16_pkg::*;
(
    // clock, reset and bus
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic [7:0]  bus_addr,
    input wire logic [7:0]  bus_wdata,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic [7:0]  bus_rdata,
    // settings and results
    input wire logic [1:0]  waveform_mode_lo,
    input wire logic [1:0]  compare_output_mode_a,
    input wire logic [1:0]  compare_output_mode_b,
    input wire logic [15:0] counter_value,
    input wire logic [15:0] capture_value,
    input wire logic        capture_flag,
    input wire logic        compare_match_a,
    input wire logic        compare_match_b,
    input wire logic        waveform_out_a,
    input wire logic        waveform_out_b
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // mode bits 3:2 are hidden, so mode 8 must not be used with a force
    logic wf;
    assign wf = bus_wr && bus_addr == FORCE_OFS && waveform_mode_lo == 2'h0;
    a_reset_clear: assert property ($rose(nrst) |-> counter_value == 16'h0000
        && capture_value == 16'h0000 && !capture_flag) else $error("reset");
    a_cnt_write: assert property (bus_wr && bus_addr == CNT_LO_OFS
        |=> counter_value[7:0] == $past(bus_wdata)) else $error("cnt wr");
    a_match_block: assert property (bus_wr && bus_addr == CNT_LO_OFS
        |-> ##2 !compare_match_a && !compare_match_b) else $error("block");
    a_force_toggle: assert property (wf && bus_wdata[FORCE_A_BIT]
        && compare_output_mode_a == COM_TOGGLE
        |=> waveform_out_a != $past(waveform_out_a)) else $error("tog a");
    a_force_set: assert property (wf && bus_wdata[FORCE_B_BIT]
        && compare_output_mode_b == COM_SET |=> waveform_out_b)
        else $error("set b");
    a_pwm_ignore: assert property (bus_wr && bus_addr == FORCE_OFS
        && waveform_mode_lo != 2'h0
        |=> $stable(waveform_out_a) && $stable(waveform_out_b))
        else $error("pwm");
    a_force_read: assert property (bus_rd && bus_addr == FORCE_OFS
        |=> bus_rdata == 8'h00) else $error("force rd");
    a_flag_clear: assert property (bus_wr && bus_addr == FLAG_OFS
        && bus_wdata[CAP_FLAG_BIT] |=> !capture_flag || $changed(capture_value))
        else $error("flag clr");
    a_capture_flag: assert property ($changed(capture_value)
        && !$past(bus_wr) |-> capture_flag) else $error("cap flag");
endmodule : timer16_properties
bind timer16_capture_clock_control timer16_properties timer16_properties_i (
    .core_clk, .nrst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .waveform_mode_lo, .compare_output_mode_a, .compare_output_mode_b,
    .counter_value, .capture_value, .capture_flag, .compare_match_a,
    .compare_match_b, .waveform_out_a, .waveform_out_b);

// ==== testbench/cpu_model.sv ====
`timescale 1ns/10ps
module cpu_model (
    // bus side
    input  wire logic       core_clk,
    input  wire logic [7:0] bus_rdata,
    output logic      [7:0] bus_addr,
    output logic      [7:0] bus_wdata,
    output logic            bus_wr,
    output logic            bus_rd
);
    initial begin
        bus_addr = 8'hFF;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    end
    // released lines show the inverse, never the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge core_clk);
        bus_wr <= 1'b0;
        bus_addr <= ~a;
        bus_wdata <= ~d;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        bus_addr <= ~a;
        #1 d = bus_rdata;
    endtask : rd
    // high byte first, the low write commits both
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a + 8'h01, v[15:8]);
        wr(a, v[7:0]);
    endtask : wr16
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a + 8'h01, v[15:8]);
    endtask : rd16
endmodule : cpu_model

// ==== testbench/timer16_capture_clock_control_tb_top.sv ====
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin \
    error_cnt++; $display("ERROR %s exp %h got %h", n, e, s); end end
module timer16_capture_clock_control_tb_top import timer16_pkg::*;;
    logic        core_clk, nrst, capture_pin, ext_count_pin, bus_wr, bus_rd;
    logic        comparator_out, capture_src_comparator, capture_vector_ack;
    logic [1:0]  waveform_mode_lo, compare_output_mode_a;
    logic [1:0]  compare_output_mode_b;
    logic [7:0]  bus_addr, bus_wdata, bus_rdata, d;
    logic [15:0] compare_a_value, compare_b_value, counter_value;
    logic [15:0] capture_value, v;
    logic        capture_flag, compare_match_a, compare_match_b;
    logic        waveform_out_a, waveform_out_b;
    int          error_cnt, checks, n, k;
    cpu_model cpu_model_i (.core_clk, .bus_rdata, .bus_addr, .bus_wdata,
                           .bus_wr, .bus_rd);
    timer16_capture_clock_control timer16_capture_clock_control_i (
        .core_clk, .nrst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
        .bus_rdata, .capture_pin, .ext_count_pin, .comparator_out,
        .capture_src_comparator, .waveform_mode_lo, .compare_output_mode_a,
        .compare_output_mode_b, .compare_a_value, .compare_b_value,
        .capture_vector_ack, .counter_value, .capture_value, .capture_flag,
        .compare_match_a, .compare_match_b, .waveform_out_a, .waveform_out_b);
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic stop_test();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic cyc(input int c);
        repeat (c) @(posedge core_clk);
    endtask : cyc
    // cycles until the counter moves, capped so a stopped counter returns
    task automatic gap(output int g);
        logic [15:0] c;
        c = counter_value;
        g = 0;
        while (counter_value === c && g < 3000) begin
            @(posedge core_clk);
            #1 g++;
        end
    endtask : gap
    task automatic t_regs();
        cpu_model_i.rd16(CNT_LO_OFS, v);
        `CHK("cnt", 16'h0000, v)
        cpu_model_i.rd(CTRL_B_OFS, d);
        `CHK("ctrl", 8'h00, d)
        cpu_model_i.wr(CTRL_B_OFS, 8'hF8);
        cpu_model_i.rd(CTRL_B_OFS, d);
        `CHK("ctrl", 8'hD8, d)
        cpu_model_i.rd(8'h00, d);
        `CHK("unmapped", 8'h00, d)
        cpu_model_i.wr(CTRL_B_OFS, 8'h00);
    endtask : t_regs
    task automatic t_cnt16();
        cpu_model_i.wr16(CNT_LO_OFS, 16'h1234);
        cpu_model_i.wr16(CAP_LO_OFS, 16'hABCD);
        cpu_model_i.rd16(CNT_LO_OFS, v);
        `CHK("cnt", 16'h1234, v)
        cpu_model_i.rd16(CAP_LO_OFS, v);
        `CHK("cap", 16'hABCD, v)
        cpu_model_i.wr(CNT_HI_OFS, 8'h77);
        cpu_model_i.wr(CAP_LO_OFS, 8'h01);
        `CHK("shared", 16'h7701, capture_value)
    endtask : t_cnt16
    task automatic t_clk();
        int div [5] = '{1, 8, 64, 256, 1024};
        for (int i = 0; i < 5; i++) begin
            cpu_model_i.wr(CTRL_B_OFS, 8'(i + 1));
            gap(n);
            gap(n);
            `CHK("div", div[i], n)
        end
        cpu_model_i.wr(CTRL_B_OFS, 8'h00);
        gap(n);
        `CHK("stop", 3000, n)
    endtask : t_clk
    task automatic t_ext();
        for (int e = 6; e < 8; e++) begin
            cpu_model_i.wr(CTRL_B_OFS, 8'(e));
            cyc(8);
            v = counter_value;
            repeat (4) begin
                ext_count_pin <= 1'b1;
                cyc(8);
                ext_count_pin <= 1'b0;
                cyc(8);
            end
            `CHK("ext", v + 16'h0004, counter_value)
        end
    endtask : t_ext
    task automatic t_cap(input logic flt, input logic edg, output int g);
        capture_pin <= ~edg;
        cpu_model_i.wr(CTRL_B_OFS, {flt, edg, 6'h01});
        cyc(10);
        cpu_model_i.wr(FLAG_OFS, 8'h20);
        `CHK("clr", 1'b0, capture_flag)
        if (flt) begin
            cyc(1);
            capture_pin <= edg;
            cyc(2);
            capture_pin <= ~edg;
            cyc(20);
            `CHK("glitch", 1'b0, capture_flag)
        end
        // launch on the edge so both filter settings are timed alike
        cyc(1);
        capture_pin <= edg;
        #1 v = counter_value;
        g = 0;
        while (capture_flag !== 1'b1 && g < 40) begin
            @(posedge core_clk);
            #1 g++;
        end
        `CHK("flag", 1'b1, capture_flag)
        `CHK("capval", v + 16'(g) - 16'h0001, capture_value)
        cyc(1);
        capture_vector_ack <= 1'b1;
        cyc(1);
        capture_vector_ack <= 1'b0;
        #1 `CHK("ack", 1'b0, capture_flag)
        cyc(1);
        capture_pin <= ~edg;
        cyc(20);
        `CHK("wrong", 1'b0, capture_flag)
    endtask : t_cap
    task automatic t_force();
        cpu_model_i.wr(CTRL_B_OFS, 8'h08);
        v = counter_value;
        d[0] = waveform_out_a;
        compare_output_mode_a <= COM_TOGGLE;
        compare_output_mode_b <= COM_SET;
        cpu_model_i.wr(FORCE_OFS, 8'hC0);
        `CHK("tog", ~d[0], waveform_out_a)
        `CHK("set", 1'b1, waveform_out_b)
        `CHK("nocl", v, counter_value)
        `CHK("noflag", 1'b0, capture_flag)
        compare_output_mode_b <= COM_CLEAR;
        cpu_model_i.wr(FORCE_OFS, 8'h40);
        `CHK("clr", 1'b0, waveform_out_b)
        cpu_model_i.rd(FORCE_OFS, d);
        `CHK("frd", 8'h00, d)
        waveform_mode_lo <= 2'h1;
        compare_output_mode_b <= COM_SET;
        cpu_model_i.wr(FORCE_OFS, 8'h40);
        `CHK("pwm", 1'b0, waveform_out_b)
        waveform_mode_lo <= 2'h0;
        cpu_model_i.wr(CTRL_B_OFS, 8'h18);
        capture_pin <= ~capture_pin;
        cyc(10);
        capture_pin <= ~capture_pin;
        cyc(10);
        `CHK("captop", 1'b0, capture_flag)
        cpu_model_i.wr16(CAP_LO_OFS, 16'h0010);
        cpu_model_i.wr16(CNT_LO_OFS, 16'h0000);
        cpu_model_i.wr(CTRL_B_OFS, 8'h19);
        cyc(40);
        `CHK("topflag", 1'b1, capture_flag)
    endtask : t_force
    task automatic t_block(input logic [15:0] c, input int ea, input int eb);
        cpu_model_i.wr16(CNT_LO_OFS, c);
        n = 0;
        k = 0;
        repeat (20) begin
            @(posedge core_clk);
            #1 if (compare_match_a === 1'b1) n++;
            if (compare_match_b === 1'b1) k++;
        end
        `CHK("match a", ea, n)
        `CHK("match b", eb, k)
    endtask : t_block
    initial begin
        {nrst, capture_pin, ext_count_pin, comparator_out} = 4'h0;
        {capture_src_comparator, capture_vector_ack} = 2'h0;
        {waveform_mode_lo, compare_output_mode_a} = 4'h0;
        compare_output_mode_b = 2'h0;
        compare_a_value = 16'h0100;
        compare_b_value = 16'h0104;
        error_cnt = 0;
        checks = 0;
        cyc(3);
        nrst <= 1'b1;
        t_regs();
        t_cnt16();
        t_clk();
        t_ext();
        t_cap(1'b0, 1'b0, n);
        t_cap(1'b0, 1'b1, k);
        t_cap(1'b1, 1'b1, n);
        `CHK("delay", 4, n - k)
        capture_src_comparator <= 1'b1;
        cyc(4);
        comparator_out <= 1'b1;
        cyc(10);
        `CHK("cmp src", 1'b1, capture_flag)
        capture_src_comparator <= 1'b0;
        cpu_model_i.wr(FLAG_OFS, 8'h20);
        `CHK("cmp clr", 1'b0, capture_flag)
        t_force();
        cpu_model_i.wr(CTRL_B_OFS, 8'h01);
        t_block(16'h0100, 0, 1);
        t_block(16'h00F8, 1, 1);
        t_block(16'h0104, 0, 0);
        stop_test();
    end
    initial begin
        #1000000;
        error_cnt++;
        stop_test();
    end
endmodule : timer16_capture_clock_control_tb_top
